// ### rx_lane_defs.svh
// constants for the receive lane sync and rate-match block
`ifndef RX_LANE_DEFS_SVH
`define RX_LANE_DEFS_SVH

// code group bytes
`define CODE_COMMA    8'hBC
`define CODE_D16_2    8'h50
`define CODE_D2_2     8'h42
`define CODE_SKIP     8'hFD

// sync machine figures, gigabit ethernet
`define GBE_SETS      7'h03
`define GBE_ERR_LIM   3'h4
`define GBE_RUN_LIM   8'h04
// sync machine figures, serial rapidio
`define SRIO_COMMAS   7'h7F
`define SRIO_ERR_LIM  3'h3
`define SRIO_RUN_LIM  8'hFF

// symbol word layout {disp, ctrl, byte}
`define SYM_W         10
`define SYM_DISP      9
`define SYM_CTRL      8

// rate-match buffer
`define FIFO_DEPTH    4
`define FIFO_HI       3'h3
`define FIFO_LO       3'h1
`define FLAG_CYC_GBE  2'h2
`define FLAG_CYC_SRIO 2'h1

// local symbol period and its cycle count
`define CLK_NS        50
`define REF_SYM_NS    400
`define RD_DIV        (`REF_SYM_NS / `CLK_NS)

`endif

// ### rx_lane_pkg.sv
// types shared by the receive lane block
package rx_lane_pkg;
	typedef enum logic {st_loss, st_sync} sync_state_e;
	typedef logic [9:0] sym_t;
endpackage

// ### rx_lane_sync_rate_match.sv
// receive lane: code-group sync machine and elastic rate-match buffer
// Notes on behaviour
// - gbe set is comma plus odd data count
// - gbe sync after three good sets
// - lose sync at four gbe, three srio errors
// - good run of 4/255 decrements error count
// - srio sync after 127 good commas
// - 7 or 10-bit align gbe, 10 srio
// - buffer absorbs plus minus 100 ppm offset
// - gbe rate matching only once synchronised
// - gbe adds/removes whole comma D16.2 idles
// - with negotiation, also comma D2.2 pairs
// - gbe insert/delete flags high two cycles
// - gbe corrections rounded up to even symbols
// - no self-escape; full/empty flags held high
// - srio patterns comma and K29.7 both disparities
// - srio rate matching only after sync
// - srio adds/removes skip after its control
// - srio one skip change per cluster
// - no lane alignment or deskew across lanes
`timescale 1ns/1ns
`include "rx_lane_defs.svh"

// small elastic fifo, valid/ready both sides
module rx_elastic_fifo
	import rx_lane_pkg::*;
#(
	parameter int W = 10,
	parameter int D = 4
)(
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	input  wire logic         clr_i,
	// fill side
	input  wire logic         wr_valid_i,
	input  wire logic [W-1:0] wr_data_i,
	output logic              wr_ready_o,
	// drain side
	output logic              rd_valid_o,
	output logic [W-1:0]      rd_data_o,
	input  wire logic         rd_ready_i,
	// level
	output logic [2:0]        level_o
);
	logic [W-1:0] mem_ff [D];
	logic [1:0]   wp_ff, rp_ff, nxt_wp, nxt_rp;
	logic [2:0]   cnt_ff, nxt_cnt;
	logic         wr_go, rd_go;

	assign wr_ready_o = (cnt_ff != 3'(D));
	assign rd_valid_o = (cnt_ff != 3'h0);
	assign rd_data_o  = mem_ff[rp_ff];
	assign level_o    = cnt_ff;

	// pointer arithmetic; depth is a power of two so pointers wrap
	always_comb
	begin
		wr_go   = wr_valid_i && wr_ready_o;
		rd_go   = rd_ready_i && rd_valid_o;
		nxt_wp  = clr_i ? 2'h0 : wp_ff + 2'(wr_go);
		nxt_rp  = clr_i ? 2'h0 : rp_ff + 2'(rd_go);
		nxt_cnt = clr_i ? 3'h0 : cnt_ff + 3'(wr_go) - 3'(rd_go);
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wp_ff  <= 2'h0;
			rp_ff  <= 2'h0;
			cnt_ff <= 3'h0;
		end
		else
		begin
			wp_ff  <= nxt_wp;
			rp_ff  <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	// storage needs no reset; contents are masked by the count
	always_ff @(posedge clk_i)
	begin
		if (wr_go)
			mem_ff[wp_ff] <= wr_data_i;
	end
endmodule

// top: sync machine, symbol hold, buffer and read-side replay
module rx_lane_sync_rate_match
	import rx_lane_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	// link side, decoded code groups on the link clock
	input  wire logic       link_clk_i,
	input  wire logic [7:0] link_data_i,
	input  wire logic       link_ctrl_i,
	input  wire logic       link_disp_i,
	input  wire logic       link_err_i,
	// configuration and control from fabric
	input  wire logic       gbe_mode_i,
	input  wire logic       align7_en_i,
	input  wire logic       an_en_i,
	input  wire logic       rm_en_i,
	input  wire logic       rx_digital_rst_i,
	// status
	output logic            sync_o,
	output logic            align10_o,
	output logic            del_o,
	output logic            ins_o,
	output logic            full_o,
	output logic            empty_o,
	// parallel data to fabric
	output logic [7:0]      data_o,
	output logic            ctrl_o,
	output logic            valid_o
);
	// link sampling: every link pin passes two flops first
	logic [2:0]   lk_ff;
	sym_t         sym_s1_ff, sym_s2_ff;
	logic         err_s1_ff, err_s2_ff;
	logic         stb;
	sym_t         sym;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			lk_ff     <= 3'h0;
			sym_s1_ff <= 10'h000;
			sym_s2_ff <= 10'h000;
			err_s1_ff <= 1'b0;
			err_s2_ff <= 1'b0;
		end
		else
		begin
			lk_ff     <= {lk_ff[1:0], link_clk_i};
			sym_s1_ff <= {link_disp_i, link_ctrl_i, link_data_i};
			sym_s2_ff <= sym_s1_ff;
			err_s1_ff <= link_err_i;
			err_s2_ff <= err_s1_ff;
		end
	end
	assign stb = lk_ff[1] && !lk_ff[2];
	assign sym = sym_s2_ff;

	// no cross-lane deskew: each lane instance stands alone
	assign align10_o = !(gbe_mode_i && align7_en_i);

	// sync machine
	sync_state_e st_ff, nxt_st;
	logic [6:0]  good_ff, nxt_good;
	logic [2:0]  err_ff, nxt_err;
	logic [7:0]  run_ff, nxt_run;
	logic        dpar_ff, nxt_dpar, seen_ff, nxt_seen;
	logic        is_comma, good_cg, bad_cg, sync_hit;
	logic [2:0]  err_lim;
	logic [7:0]  run_lim;

	always_comb
	begin
		is_comma = sym[`SYM_CTRL] && (sym[7:0] == `CODE_COMMA) && !err_s2_ff;
		err_lim  = gbe_mode_i ? `GBE_ERR_LIM : `SRIO_ERR_LIM;
		run_lim  = gbe_mode_i ? `GBE_RUN_LIM : `SRIO_RUN_LIM;
		// gbe comma on an odd boundary counts as an error
		bad_cg   = err_s2_ff || (gbe_mode_i && is_comma && seen_ff && !dpar_ff);
		good_cg  = !bad_cg;
		sync_hit = gbe_mode_i ? (good_ff == `GBE_SETS - 7'h1)
		                      : (good_ff == `SRIO_COMMAS - 7'h1);
		nxt_st   = st_ff;
		nxt_good = good_ff;
		nxt_err  = err_ff;
		nxt_run  = run_ff;
		nxt_dpar = dpar_ff;
		nxt_seen = seen_ff;
		if (rx_digital_rst_i)
		begin
			nxt_st   = st_loss;
			nxt_good = 7'h00;
			nxt_err  = 3'h0;
			nxt_run  = 8'h00;
			nxt_dpar = 1'b0;
			nxt_seen = 1'b0;
		end
		else if (stb)
		begin
			nxt_dpar = is_comma ? 1'b0 : !dpar_ff;
			nxt_seen = seen_ff || is_comma;
			if (st_ff == st_loss)
			begin
				if (bad_cg)
					nxt_good = 7'h00;
				// gbe counts a set when the next comma closes it
				else if (is_comma && (!gbe_mode_i || seen_ff))
				begin
					nxt_good = good_ff + 7'h1;
					if (sync_hit)
					begin
						nxt_st   = st_sync;
						nxt_err  = 3'h0;
						nxt_run  = 8'h00;
					end
				end
			end
			else if (bad_cg)
			begin
				nxt_run = 8'h00;
				nxt_err = err_ff + 3'h1;
				if (err_ff + 3'h1 == err_lim)
				begin
					nxt_st   = st_loss;
					nxt_good = 7'h00;
					nxt_seen = 1'b0;
				end
			end
			else if (err_ff != 3'h0)
			begin
				if (run_ff == run_lim - 8'h1)
				begin
					nxt_err = err_ff - 3'h1;
					nxt_run = 8'h00;
				end
				else
					nxt_run = run_ff + 8'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_ff   <= st_loss;
			good_ff <= 7'h00;
			err_ff  <= 3'h0;
			run_ff  <= 8'h00;
			dpar_ff <= 1'b0;
			seen_ff <= 1'b0;
		end
		else
		begin
			st_ff   <= nxt_st;
			good_ff <= nxt_good;
			err_ff  <= nxt_err;
			run_ff  <= nxt_run;
			dpar_ff <= nxt_dpar;
			seen_ff <= nxt_seen;
		end
	end
	assign sync_o = (st_ff == st_sync);

	// rate matching: one held symbol lets a pair be judged whole
	logic        act, hv_ff, nxt_hv, cl_ff, nxt_cl, gbe_pair, srio_pair, del_ev, ins_ev;
	sym_t        hold_ff, nxt_hold, o0_ff, o1_ff, nxt_o0, nxt_o1, wr_d;
	logic        wr_v, wr_rdy, rd_v, rd_pop, rd_stb;
	sym_t        rd_d;
	logic [2:0]  lvl, div_ff, nxt_div;
	logic [1:0]  rep_ff, nxt_rep, dcnt_ff, icnt_ff, nxt_dcnt, nxt_icnt, flag_cyc;
	logic        full_ff, empty_ff, nxt_full, nxt_empty, vo_ff, nxt_vo;
	sym_t        do_ff, nxt_do;
	logic        hold_comma, ins_pair;

	// buffer written on link strobes, read at the local symbol rate
	rx_elastic_fifo #(.W(`SYM_W), .D(`FIFO_DEPTH)) i_rx_elastic_fifo (
		.clk_i      (clk_i),
		.arst_n_i   (arst_n_i),
		.clr_i      (rx_digital_rst_i || !sync_o),
		.wr_valid_i (wr_v),
		.wr_data_i  (wr_d),
		.wr_ready_o (wr_rdy),
		.rd_valid_o (rd_v),
		.rd_data_o  (rd_d),
		.rd_ready_i (rd_pop),
		.level_o    (lvl)
	);

	always_comb
	begin
		// srio matching is optional and gated by rm_en_i
		act        = sync_o && (gbe_mode_i || rm_en_i);
		flag_cyc   = gbe_mode_i ? `FLAG_CYC_GBE : `FLAG_CYC_SRIO;
		hold_comma = hv_ff && hold_ff[`SYM_CTRL] && (hold_ff[7:0] == `CODE_COMMA);
		gbe_pair   = gbe_mode_i && hold_comma && !sym[`SYM_CTRL] &&
		             ((sym[7:0] == `CODE_D16_2) ||
		              (an_en_i && sym[7:0] == `CODE_D2_2));
		// skip must carry its control's disparity
		srio_pair  = !gbe_mode_i && hold_comma && sym[`SYM_CTRL] &&
		             (sym[7:0] == `CODE_SKIP) && (sym[`SYM_DISP] == hold_ff[`SYM_DISP]);
		del_ev     = stb && act && (lvl >= `FIFO_HI) &&
		             (gbe_pair || (srio_pair && !cl_ff));
		rd_stb     = (div_ff == 3'(`RD_DIV - 1));
		ins_pair   = gbe_mode_i
		           ? (o0_ff[`SYM_CTRL] && o0_ff[7:0] == `CODE_COMMA && !o1_ff[`SYM_CTRL] &&
		              (o1_ff[7:0] == `CODE_D16_2 || (an_en_i && o1_ff[7:0] == `CODE_D2_2)))
		           : (o0_ff[`SYM_CTRL] && o0_ff[7:0] == `CODE_COMMA &&
		              o1_ff[`SYM_CTRL] && o1_ff[7:0] == `CODE_SKIP && !cl_ff);
		ins_ev     = rd_stb && act && rep_ff == 2'h0 && lvl <= `FIFO_LO && ins_pair;
		nxt_div    = rd_stb ? 3'h0 : div_ff + 3'h1;
		nxt_hold   = hold_ff;
		nxt_hv     = hv_ff;
		nxt_cl     = cl_ff;
		wr_v       = 1'b0;
		wr_d       = hold_ff;
		if (stb && sync_o)
		begin
			// whole gbe pair dropped, even count kept srio drops the skip only
			wr_v     = hv_ff && !(del_ev && gbe_mode_i);
			nxt_hold = sym;
			nxt_hv   = !del_ev;
			if (!sym[`SYM_CTRL] || (sym[7:0] != `CODE_COMMA && sym[7:0] != `CODE_SKIP))
				nxt_cl = 1'b0;
		end
		if (del_ev || ins_ev)
			nxt_cl = !gbe_mode_i;
		if (!sync_o)
			nxt_hv = 1'b0;
		// replay: emitting o0 and rotating keeps the pair, srio repeats skip
		nxt_rep = ins_ev ? (gbe_mode_i ? 2'h2 : 2'h1) : rep_ff;
		rd_pop  = 1'b0;
		nxt_vo  = 1'b0;
		nxt_do  = do_ff;
		nxt_o0  = o0_ff;
		nxt_o1  = o1_ff;
		if (rd_stb && act && !ins_ev && rep_ff != 2'h0)
		begin
			nxt_rep = rep_ff - 2'h1;
			nxt_vo  = 1'b1;
			nxt_do  = gbe_mode_i ? o0_ff : o1_ff;
			nxt_o0  = o1_ff;
			nxt_o1  = nxt_do;
		end
		else if (rd_stb && sync_o && !ins_ev && rd_v)
		begin
			rd_pop = 1'b1;
			nxt_vo = 1'b1;
			nxt_do = rd_d;
			nxt_o0 = o1_ff;
			nxt_o1 = rd_d;
		end
		// flags stay up until the fabric resets the receiver
		// an event in the reset cycle itself still sets the flag: the set wins
		nxt_full  = (full_ff && !rx_digital_rst_i) || (wr_v && !wr_rdy);
		nxt_empty = (empty_ff && !rx_digital_rst_i) ||
		            (rd_stb && sync_o && hv_ff && !rd_v && rep_ff == 2'h0 && !ins_ev);
		nxt_dcnt  = del_ev ? flag_cyc : (dcnt_ff != 2'h0 ? dcnt_ff - 2'h1 : 2'h0);
		nxt_icnt  = ins_ev ? flag_cyc : (icnt_ff != 2'h0 ? icnt_ff - 2'h1 : 2'h0);
		if (rx_digital_rst_i)
			nxt_hv = 1'b0;
		// a receiver reset or lost sync must not let an old pair be replayed later
		if (rx_digital_rst_i || !sync_o)
		begin
			nxt_rep = 2'h0;
			nxt_o0  = 10'h000;
			nxt_o1  = 10'h000;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			hold_ff  <= 10'h000;
			hv_ff    <= 1'b0;
			cl_ff    <= 1'b0;
			o0_ff    <= 10'h000;
			o1_ff    <= 10'h000;
			rep_ff   <= 2'h0;
			div_ff   <= 3'h0;
			full_ff  <= 1'b0;
			empty_ff <= 1'b0;
			dcnt_ff  <= 2'h0;
			icnt_ff  <= 2'h0;
			vo_ff    <= 1'b0;
			do_ff    <= 10'h000;
		end
		else
		begin
			hold_ff  <= nxt_hold;
			hv_ff    <= nxt_hv;
			cl_ff    <= nxt_cl;
			o0_ff    <= nxt_o0;
			o1_ff    <= nxt_o1;
			rep_ff   <= nxt_rep;
			div_ff   <= nxt_div;
			full_ff  <= nxt_full;
			empty_ff <= nxt_empty;
			dcnt_ff  <= nxt_dcnt;
			icnt_ff  <= nxt_icnt;
			vo_ff    <= nxt_vo;
			do_ff    <= nxt_do;
		end
	end

	assign del_o   = (dcnt_ff != 2'h0);
	assign ins_o   = (icnt_ff != 2'h0);
	assign full_o  = full_ff;
	assign empty_o = empty_ff;
	assign valid_o = vo_ff;
	assign data_o  = do_ff[7:0];
	assign ctrl_o  = do_ff[`SYM_CTRL];

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	property p_gbe_sets;
		$rose(sync_o) && gbe_mode_i |-> $past(good_ff) == 7'h02;
	endproperty
	a_gbe_sets: assert property (p_gbe_sets) else $error("gbe sync set count");

	property p_srio_commas;
		$rose(sync_o) && !gbe_mode_i |-> $past(good_ff) == 7'h7E;
	endproperty
	a_srio_commas: assert property (p_srio_commas) else $error("srio comma count");

	property p_lose;
		sync_o && stb && bad_cg && !rx_digital_rst_i && err_ff == err_lim - 3'h1 |=> !sync_o;
	endproperty
	a_lose: assert property (p_lose) else $error("sync not lost");

	property p_run;
		sync_o && stb && good_cg && !rx_digital_rst_i && err_ff != 3'h0 &&
		run_ff == run_lim - 8'h1 |=> err_ff == $past(err_ff) - 3'h1;
	endproperty
	a_run: assert property (p_run) else $error("error count not reduced");

	property p_quiet;
		!sync_o |-> !del_ev && !ins_ev;
	endproperty
	a_quiet: assert property (p_quiet) else $error("rate match while unsynced");

	property p_flag_two;
		del_ev && gbe_mode_i |=> del_o [*2];
	endproperty
	a_flag_two: assert property (p_flag_two) else $error("delete flag width");

	property p_full_hold;
		full_o && !rx_digital_rst_i |=> full_o;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full flag dropped");

	property p_cluster;
		(del_ev || ins_ev) && !gbe_mode_i |=> cl_ff;
	endproperty
	a_cluster: assert property (p_cluster) else $error("cluster not marked");

	property p_align;
		!gbe_mode_i |-> align10_o;
	endproperty
	a_align: assert property (p_align) else $error("srio align width");

	c_sync:  cover property ($rose(sync_o));
	c_del:   cover property (del_ev && gbe_mode_i);
	c_ins:   cover property (ins_ev && !gbe_mode_i);
	c_empty: cover property ($rose(empty_o));
endmodule

// ### rx_link_tx_model.sv
// remote transmitter model: decoded code groups on a gated link clock
`timescale 1ns/1ns
module rx_link_tx_model
(
	// link side
	output logic       link_clk_o,
	output logic [7:0] link_data_o,
	output logic       link_ctrl_o,
	output logic       link_disp_o,
	output logic       link_err_o
);
	logic [10:0] last;

	// link clock idles low outside frames
	initial
	begin
		last = '0;
		{link_clk_o, link_data_o, link_ctrl_o, link_disp_o, link_err_o} = '0;
	end

	// one group per call, {err, disp, ctrl, byte}; lines change on the falling edge
	// non-blocking so the local clock never races a change made on its edge
	task automatic send(input logic [10:0] s, input int half);
	begin
		last = s;
		{link_err_o, link_disp_o, link_ctrl_o, link_data_o} <= s;
		#half link_clk_o <= 1'b1;
		#half link_clk_o <= 1'b0;
	end
	endtask

	// idle lines show inverted junk so a stale value cannot pass
	task automatic rest();
		{link_err_o, link_disp_o, link_ctrl_o, link_data_o} <= ~last;
	endtask
endmodule

// ### rx_lane_sync_rate_match_bench.sv
// self-checking bench for the receive lane sync and rate-match block
`timescale 1ns/1ns
`include "rx_lane_defs.svh"
module rx_lane_sync_rate_match_bench
	import rx_lane_pkg::*;
;
	localparam logic [10:0] COMMA = {3'b011, `CODE_COMMA};
	localparam logic [10:0] SKIP  = {3'b011, `CODE_SKIP};
	localparam logic [10:0] ERR   = 11'h400;
	localparam int          NOM   = 200; // nominal half period, same rate both ends
	logic        clk, arst_n, gbe_mode, align7_en, an_en, rm_en, dig_rst;
	logic        sync, align10, del, ins, full, empty, ctrl, valid;
	logic        lclk, lctrl, ldisp, lerr;
	logic [7:0]  ldata, data, b1;
	logic [31:0] seed = 32'hE9C25362;
	int          num_errors, checks_done, dels, inss, dw, iw, del_w, ins_w, n0;

	rx_lane_sync_rate_match i_rx_lane_sync_rate_match (.clk_i(clk), .arst_n_i(arst_n),
		.link_clk_i(lclk), .link_data_i(ldata), .link_ctrl_i(lctrl), .link_disp_i(ldisp),
		.link_err_i(lerr), .gbe_mode_i(gbe_mode), .align7_en_i(align7_en), .an_en_i(an_en),
		.rm_en_i(rm_en), .rx_digital_rst_i(dig_rst), .sync_o(sync), .align10_o(align10),
		.del_o(del), .ins_o(ins), .full_o(full), .empty_o(empty), .data_o(data),
		.ctrl_o(ctrl), .valid_o(valid));
	rx_link_tx_model i_rx_link_tx_model (.link_clk_o(lclk), .link_data_o(ldata),
		.link_ctrl_o(lctrl), .link_disp_o(ldisp), .link_err_o(lerr));

	// local clock, 50 ns
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// flag pulse counters; widths kept for checking
	always @(posedge clk)
	begin
		if (del === 1'b1) dw++;
		else if (dw != 0)
		begin
			del_w = dw;
			dels++;
			dw = 0;
		end
		if (ins === 1'b1) iw++;
		else if (iw != 0)
		begin
			ins_w = iw;
			inss++;
			iw = 0;
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic close_out();
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic tx(input logic [10:0] s, input int half);
		i_rx_link_tx_model.send(s, half);
	endtask

	// random data groups, never control
	task automatic txd(input int n, input int half);
		repeat (n) tx({3'b000, 8'(rnd())}, half);
	endtask

	task automatic fab_rst();
		@(posedge clk);
		i_rx_link_tx_model.rest();
		dig_rst <= 1'b1;
		@(posedge clk);
		dig_rst <= 1'b0;
		ticks(2);
	endtask

	// bounded wait for a counter to move; a timeout ends the run
	task automatic wait_cnt(ref int cnt, input int old, input string nm);
		for (int i = 0; i < 3000 && cnt == old; i++) @(posedge clk);
		chk(nm, 32'(cnt != old), 1);
		if (cnt == old) close_out();
	endtask

	task automatic wait_flag(input logic sel, input string nm);
		int i;
		for (i = 0; i < 3000 && (sel ? empty : full) !== 1'b1; i++) @(posedge clk);
		chk(nm, sel ? empty : full, 1);
		if (i == 3000) close_out();
	endtask

	task automatic gbe_sync();
		tx(COMMA, NOM);
		repeat (2)
		begin
			txd(1, NOM);
			tx(COMMA, NOM);
		end
		ticks(6);
		chk("sync_two_sets", sync, 0);
		txd(1, NOM);
		tx(COMMA, NOM);
		ticks(6);
		chk("sync_three_sets", sync, 1);
	endtask

	initial
	begin
		{arst_n, gbe_mode, align7_en, an_en, rm_en, dig_rst} = '0;
		ticks(20);
		arst_n <= 1'b1;
		ticks(2);
		chk("rst_flags", {sync, del, ins, full, empty, valid}, 0);
		// aligner width over all mode pairs
		for (int m = 0; m < 4; m++)
		begin
			gbe_mode <= m[1];
			align7_en <= m[0];
			ticks(2);
			chk("align10", align10, !(m[1] && m[0]));
		end
		align7_en <= 1'b0;
		fab_rst();
		gbe_sync();
		repeat (3) tx(ERR, NOM);
		ticks(6);
		chk("sync_3err", sync, 1);
		txd(4, NOM);
		tx(ERR, NOM);
		ticks(6);
		chk("sync_decrement", sync, 1);
		tx(ERR, NOM);
		ticks(6);
		chk("sync_4err", sync, 0);
		// fast idle pairs force deletion, then silence forces insertion
		for (int k = 0; k < 2; k++)
		begin
			an_en <= k[0];
			fab_rst();
			gbe_sync();
			n0 = dels;
			repeat (12)
			begin
				tx({3'b000, k[0] ? `CODE_D2_2 : `CODE_D16_2}, 100);
				tx(COMMA, 100);
			end
			wait_cnt(dels, n0, "del_seen");
			chk("del_width", del_w, 2);
			n0 = inss;
			wait_cnt(inss, n0, "ins_seen");
			chk("ins_width", ins_w, 2);
		end
		// data only: no escape from full, fabric reset clears it
		fab_rst();
		gbe_sync();
		n0 = dels;
		txd(16, 100);
		wait_flag(1'b0, "full_set");
		ticks(2);
		chk("full_held", full, 1);
		chk("no_drop", dels, n0);
		fab_rst();
		chk("full_clear", {full, sync}, 0);
		gbe_sync();
		n0 = inss;
		b1 = 8'(rnd());
		tx({3'b000, b1}, NOM);
		txd(1, NOM);
		wait_flag(1'b1, "empty_set");
		chk("no_add", inss, n0);
		ticks(10);
		chk("data_out", {ctrl, data}, {1'b0, b1});
		// serial rapidio: no matching before sync despite fast clusters
		gbe_mode <= 1'b0;
		rm_en <= 1'b1;
		fab_rst();
		n0 = dels + inss;
		repeat (126)
		begin
			tx(COMMA, 100);
			tx(SKIP, 100);
		end
		ticks(6);
		chk("srio_126", sync, 0);
		chk("srio_no_flags", dels + inss, n0);
		tx(COMMA, NOM);
		ticks(6);
		chk("srio_127", sync, 1);
		n0 = dels;
		repeat (10)
		begin
			tx(COMMA, 100);
			tx(SKIP, 100);
		end
		txd(1, 100);
		chk("one_per_cluster", dels - n0, 1);
		n0 = dels;
		for (int c = 0; c < 8; c++)
		begin
			tx({1'b0, c[0], 1'b1, `CODE_COMMA}, 100);
			tx({1'b0, c[0], 1'b1, `CODE_SKIP}, 100);
			txd(1, 100);
		end
		wait_cnt(dels, n0, "srio_del");
		chk("srio_del_width", del_w, 1);
		repeat (2) tx(ERR, NOM);
		ticks(6);
		chk("srio_2err", sync, 1);
		tx(ERR, NOM);
		ticks(6);
		chk("srio_3err", sync, 0);
		close_out();
	end
endmodule
